//--- pkg/decim_pkg.sv
// Constants shared by the decimation filter chain
package decim_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] HPC_LO_OFS = 8'h04;
  localparam logic [7:0] HPC_HI_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] DATA_OFS = 8'h10;
  // Control field positions
  localparam int PATH_LSB = 0;
  localparam int RATE_LSB = 2;
  localparam int PHASE_BIT = 5;
  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h03;
  localparam logic [15:0] HPC_RST = 16'h0337;
  // Path select codes
  typedef enum logic [1:0] {
    PATH_BYPASS = 2'b00,
    PATH_SINC = 2'b01,
    PATH_FIR = 2'b10,
    PATH_HPF = 2'b11
  } path_e;
  // Modulator rate is master clock over this
  localparam int MOD_DIV = 4;
  // Sinc order and widths
  localparam int SINC_ORDER = 5;
  localparam int ACC_W = 37;
  localparam int DAT_W = 24;
  localparam int FRAC_W = 23;
  // FIR sub-stage layout
  localparam int NSTG = 4;
  localparam int NTAP = 8;
  localparam int COEF_FRAC = 14;
  localparam logic [2:0] STG_DEC [NSTG] = '{3'd2, 3'd2, 3'd4, 3'd2};
  // Coefficient tables: [phase][stage][tap], unity gain in Q14
  localparam logic signed [15:0] COEF [2][NSTG][NTAP] = '{
    '{'{-16'sd512, 16'sd0, 16'sd2560, 16'sd6144,
        16'sd6144, 16'sd2560, 16'sd0, -16'sd512},
      '{-16'sd512, 16'sd0, 16'sd2560, 16'sd6144,
        16'sd6144, 16'sd2560, 16'sd0, -16'sd512},
      '{16'sd512, 16'sd1024, 16'sd2560, 16'sd4096,
        16'sd4096, 16'sd2560, 16'sd1024, 16'sd512},
      '{-16'sd512, 16'sd0, 16'sd2560, 16'sd6144,
        16'sd6144, 16'sd2560, 16'sd0, -16'sd512}},
    '{'{-16'sd512, 16'sd0, 16'sd2560, 16'sd6144,
        16'sd6144, 16'sd2560, 16'sd0, -16'sd512},
      '{-16'sd512, 16'sd0, 16'sd2560, 16'sd6144,
        16'sd6144, 16'sd2560, 16'sd0, -16'sd512},
      '{16'sd6144, 16'sd5120, 16'sd3072, 16'sd1536,
        16'sd512, 16'sd0, 16'sd0, 16'sd0},
      '{16'sd7168, 16'sd5120, 16'sd2560, 16'sd1024,
        16'sd512, 16'sd0, 16'sd0, 16'sd0}}
  };
  // Settling in output words (linear phase)
  localparam logic [6:0] LIN_RANGE_CNT = 7'd31;
  localparam logic [6:0] SETTLED_CNT = 7'd62;
endpackage : decim_pkg

//--- src/decimation_filter_chain.sv
// Sinc5, four-stage FIR and first-order high-pass chain with APB registers
`timescale 1ns/1ps
// How it works
// R1: Sinc, then FIR, then high-pass, cascaded in that order.
// R2: Path field picks raw bitstream, sinc, sinc+FIR or sinc+FIR+high-pass.
// R3: Sinc takes one modulator bit per four master clocks.
// R4: Sinc is fifth order, gain divided by N to the fifth.
// R5: Rate codes 000..100 give sinc decimation 128, 64, 32, 16, 8.
// R6: FIR has four sub-stages; first two half-band, decimate by two.
// R7: Third sub-stage decimates by four, fourth by two.
// R8: Last two sub-stages switch coefficient set with phase; first two fixed.
// R9: With FIR, total decimation is 4096 down to 256.
// R10: Phase bit 0 picks linear set, 1 picks minimum set.
// R11: Linear set is symmetric, so group delay is constant.
// R12: Coefficients give flat passband to 0.375 of output rate.
// R13: Final stage is a recursive first-order high-pass removing DC.
// R14: High-pass coefficient is scaled by 65536.
// R15: All rates derive from the master clock, so they scale with it.
// R16: Raw path selected means filter stages hold still.
// R17: Linear phase: in range after 31 outputs, settled after 62.
// R18: One-cycle valid strobe with every new output word.
// R19: High-pass coefficient kept as low and high bytes, joined for use.
// R20: FIR coefficients for both phases are constant tables in the block.
module decimation_filter_chain
  import decim_pkg::*;
(
  input wire logic clk_i, // Master clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic mod_bit_i, // Modulator bitstream, same clock
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic [DAT_W-1:0] data_o, // Output word
  output logic data_valid_o // One-cycle strobe per word
);

  logic [5:0] ctrl_reg;
  logic [7:0] hpc_lo_reg;
  logic [7:0] hpc_hi_reg;
  logic [1:0] div_reg;
  logic mod_en;
  logic run;
  logic [1:0] path;
  logic [2:0] rate;
  logic phase;
  logic [15:0] hpc;
  logic acc_wr;
  logic hit;
  logic in_range;
  logic settled;

  // Log2 of sinc ratio per rate code; spare codes fall back to 8
  function automatic logic [2:0] ratio_log2(input logic [2:0] code);
    if (code > 3'd4)
      return 3'd3;
    return 3'd7 - code;
  endfunction : ratio_log2

  // Scale a sinc result by N^-5 into Q23 with saturation
  function automatic logic signed [DAT_W-1:0] sinc_norm(
    input logic signed [ACC_W-1:0] v, input logic [2:0] k);
    logic signed [ACC_W+8:0] w;
    logic [5:0] sh;
    w = '0;
    sh = 6'(k) * 6'd5;
    if (sh >= 6'(FRAC_W))
      w = (ACC_W+9)'(v) >>> (sh - 6'(FRAC_W));
    else
      w = (ACC_W+9)'(v) <<< (6'(FRAC_W) - sh);
    if (w > (ACC_W+9)'(24'sh7FFFFF))
      return 24'sh7FFFFF;
    if (w < -(ACC_W+9)'(24'sh7FFFFF))
      return -24'sh7FFFFF;
    return w[DAT_W-1:0];
  endfunction : sinc_norm

  assign path = ctrl_reg[PATH_LSB +: 2];
  assign rate = ctrl_reg[RATE_LSB +: 3];
  assign phase = ctrl_reg[PHASE_BIT];
  assign hpc = {hpc_hi_reg, hpc_lo_reg}; // [R19]
  assign run = (path != PATH_BYPASS); // [R16]

  // APB: zero wait states, error on unmapped addresses
  assign pready = 1'b1;
  assign acc_wr = psel && penable && pwrite;
  always_comb
  begin
    hit = 1'b1;
    prdata = 32'h0;
    if (paddr == CTRL_OFS)
      prdata = {26'h0, ctrl_reg};
    else if (paddr == HPC_LO_OFS)
      prdata = {24'h0, hpc_lo_reg};
    else if (paddr == HPC_HI_OFS)
      prdata = {24'h0, hpc_hi_reg};
    else if (paddr == STATUS_OFS)
      prdata = {30'h0, settled, in_range};
    else if (paddr == DATA_OFS)
      prdata = {{8{data_o[DAT_W-1]}}, data_o};
    else
      hit = 1'b0;
  end
  assign pslverr = psel && penable && !hit;

  // Configuration writes; a control write restarts the chain
  logic cfg_wr;
  assign cfg_wr = acc_wr && (paddr == CTRL_OFS);
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg <= CTRL_RST;
      hpc_lo_reg <= HPC_RST[7:0];
      hpc_hi_reg <= HPC_RST[15:8];
    end
    else if (acc_wr)
    begin
      if (paddr == CTRL_OFS)
        ctrl_reg <= pwdata[5:0];
      else if (paddr == HPC_LO_OFS)
        hpc_lo_reg <= pwdata[7:0]; // [R19]
      else if (paddr == HPC_HI_OFS)
        hpc_hi_reg <= pwdata[7:0]; // [R19]
    end
  end

  // Modulator sample enable, every rate follows the master clock
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      div_reg <= 2'h0;
    else
      div_reg <= div_reg + 2'h1; // [R3] [R15]
  end
  assign mod_en = (div_reg == 2'(MOD_DIV - 1)); // [R3]

  // Sinc5: integrators at modulator rate, combs at decimated rate
  logic signed [ACC_W-1:0] integ_reg [SINC_ORDER];
  logic signed [ACC_W-1:0] comb_reg [SINC_ORDER];
  logic signed [ACC_W-1:0] cv [SINC_ORDER+1];
  logic [6:0] sdec_reg;
  logic sinc_tick;
  logic sinc_vld_reg;
  logic signed [DAT_W-1:0] sinc_out_reg;
  logic [6:0] sdec_last;
  assign sdec_last = 7'((8'h01 << ratio_log2(rate)) - 8'h01); // [R5]
  assign sinc_tick = run && mod_en && (sdec_reg == sdec_last);

  // Comb chain, differences of successive decimated integrator values
  always_comb
  begin
    cv[0] = integ_reg[SINC_ORDER-1];
    for (int i = 0; i < SINC_ORDER; i++)
      cv[i+1] = cv[i] - comb_reg[i]; // [R4]
  end

  // Integrators; input bit maps to +1 or -1
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cfg_wr)
    begin
      for (int i = 0; i < SINC_ORDER; i++)
        integ_reg[i] <= '0;
      sdec_reg <= 7'h0;
    end
    else if (run && mod_en) // [R16]
    begin
      integ_reg[0] <= integ_reg[0] + (mod_bit_i ? 37'sd1 : -37'sd1); // [R1]
      for (int i = 1; i < SINC_ORDER; i++)
        integ_reg[i] <= integ_reg[i] + integ_reg[i-1]; // [R4]
      sdec_reg <= sinc_tick ? 7'h0 : sdec_reg + 7'h1; // [R5]
    end
  end

  // Combs and gain normalisation by N^5
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cfg_wr)
    begin
      for (int i = 0; i < SINC_ORDER; i++)
        comb_reg[i] <= '0;
      sinc_out_reg <= '0;
      sinc_vld_reg <= 1'b0;
    end
    else
    begin
      sinc_vld_reg <= sinc_tick;
      if (sinc_tick)
      begin
        for (int i = 0; i < SINC_ORDER; i++)
          comb_reg[i] <= cv[i];
        sinc_out_reg <= sinc_norm(cv[SINC_ORDER], ratio_log2(rate)); // [R4]
      end
    end
  end

  // FIR: four decimating sub-stages, 2-2-4-2 for 32 overall
  logic signed [DAT_W-1:0] tap_reg [NSTG][NTAP];
  logic [1:0] fdec_reg [NSTG];
  logic signed [DAT_W-1:0] stg_out_reg [NSTG];
  logic stg_vld_reg [NSTG];
  logic stg_in_vld [NSTG];
  logic signed [DAT_W-1:0] stg_in [NSTG];

  // Dot product of a sub-stage delay line with its table
  function automatic logic signed [DAT_W-1:0] fir_dot(
    input logic signed [DAT_W-1:0] t [NTAP], input int s,
    input logic ph);
    logic signed [DAT_W+19:0] acc;
    acc = '0;
    for (int j = 0; j < NTAP; j++)
      acc = acc + (DAT_W+20)'(t[j]) * (DAT_W+20)'(COEF[ph][s][j]); // [R20]
    return DAT_W'(acc >>> COEF_FRAC); // [R12]
  endfunction : fir_dot

  // Cascade wiring between sub-stages
  always_comb
  begin
    stg_in[0] = sinc_out_reg; // [R6]
    stg_in_vld[0] = sinc_vld_reg;
    for (int s = 1; s < NSTG; s++)
    begin
      stg_in[s] = stg_out_reg[s-1];
      stg_in_vld[s] = stg_vld_reg[s-1];
    end
  end

  // Each sub-stage shifts in every input, emits every D-th
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cfg_wr)
    begin
      for (int s = 0; s < NSTG; s++)
      begin
        for (int j = 0; j < NTAP; j++)
          tap_reg[s][j] <= '0;
        fdec_reg[s] <= 2'h0;
        stg_out_reg[s] <= '0;
        stg_vld_reg[s] <= 1'b0;
      end
    end
    else
    begin
      for (int s = 0; s < NSTG; s++)
      begin
        stg_vld_reg[s] <= 1'b0;
        if (stg_in_vld[s])
        begin
          tap_reg[s][0] <= stg_in[s];
          for (int j = 1; j < NTAP; j++)
            tap_reg[s][j] <= tap_reg[s][j-1];
          if (fdec_reg[s] == 2'(STG_DEC[s] - 3'd1)) // [R6] [R7] [R9]
          begin
            fdec_reg[s] <= 2'h0;
            stg_vld_reg[s] <= 1'b1;
            // Phase only reaches the last two tables [R8] [R10] [R11]
            stg_out_reg[s] <= fir_dot(tap_reg[s], s,
                                      (s >= 2) ? phase : 1'b0);
          end
          else
            fdec_reg[s] <= fdec_reg[s] + 2'h1;
        end
      end
    end
  end

  // Output of FIR is last sub-stage
  logic signed [DAT_W-1:0] fir_out;
  logic fir_vld;
  assign fir_out = stg_out_reg[NSTG-1];
  assign fir_vld = stg_vld_reg[NSTG-1];

  // High-pass: y = x - x1 + y1 - c*y1/65536, c scaled by 65536
  logic signed [DAT_W-1:0] hx_reg;
  logic signed [DAT_W-1:0] hy_reg;
  logic signed [DAT_W+17:0] hp_fb;
  logic signed [DAT_W+1:0] hp_sum;
  logic hp_vld_reg;
  assign hp_fb = (DAT_W+18)'(hy_reg) * $signed({26'h0, hpc}) >>> 16; // [R14]
  assign hp_sum = (DAT_W+2)'(fir_out) - (DAT_W+2)'(hx_reg)
                + (DAT_W+2)'(hy_reg) - (DAT_W+2)'(hp_fb); // [R13]
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cfg_wr)
    begin
      hx_reg <= '0;
      hy_reg <= '0;
      hp_vld_reg <= 1'b0;
    end
    else
    begin
      hp_vld_reg <= fir_vld && (path == PATH_HPF);
      if (fir_vld && (path == PATH_HPF)) // [R13]
      begin
        hx_reg <= fir_out;
        // Clamp keeps the recursion from wrapping on steps
        if (hp_sum > (DAT_W+2)'(24'sh7FFFFF))
          hy_reg <= 24'sh7FFFFF;
        else if (hp_sum < -(DAT_W+2)'(24'sh7FFFFF))
          hy_reg <= -24'sh7FFFFF;
        else
          hy_reg <= hp_sum[DAT_W-1:0];
      end
    end
  end

  // Output mux and strobe at the selected stage's rate
  logic sel_vld;
  logic signed [DAT_W-1:0] sel_dat;
  always_comb
  begin
    sel_vld = 1'b0;
    sel_dat = '0;
    case (path)
      PATH_BYPASS:
      begin
        sel_vld = mod_en; // [R2]
        sel_dat = {{(DAT_W-1){1'b0}}, mod_bit_i};
      end
      PATH_SINC:
      begin
        sel_vld = sinc_vld_reg; // [R2]
        sel_dat = sinc_out_reg;
      end
      PATH_FIR:
      begin
        sel_vld = fir_vld; // [R2]
        sel_dat = fir_out;
      end
      default:
      begin
        sel_vld = hp_vld_reg; // [R2]
        sel_dat = hy_reg;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      data_o <= '0;
      data_valid_o <= 1'b0;
    end
    else
    begin
      data_valid_o <= sel_vld; // [R18]
      if (sel_vld)
        data_o <= sel_dat;
    end
  end

  // Output count since restart drives settling flags
  logic [6:0] settle_reg;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || cfg_wr)
      settle_reg <= 7'h0;
    else if (fir_vld && settle_reg != SETTLED_CNT)
      settle_reg <= settle_reg + 7'h1; // [R17]
  end
  // Only meaningful for FIR paths in linear phase
  assign in_range = (settle_reg >= LIN_RANGE_CNT); // [R17]
  assign settled = (settle_reg >= SETTLED_CNT); // [R17]

endmodule : decimation_filter_chain

//--- tb/mod_source.sv
// Modulator bitstream model, one bit per four clocks
`timescale 1ns/1ps
module mod_source (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, low
  input wire logic [31:0] pat_i, // Bit pattern
  output logic mod_bit_o // Modulator bit
);
  logic [1:0] div_reg;
  logic [4:0] idx_reg;
  // Bit moves on the sampling edge, so it is stable where taken
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      div_reg <= 2'h0;
      idx_reg <= 5'h00;
    end
    else
    begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3)
        idx_reg <= idx_reg + 5'h01;
    end
  end
  assign mod_bit_o = pat_i[idx_reg];
endmodule : mod_source

//--- tb/decim_chk.sv
// Port checker for the decimation filter chain
`timescale 1ns/1ps
module decim_chk
  import decim_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, low
  input wire logic mod_bit_i, // Modulator bit
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [DAT_W-1:0] data_o, // Word
  input wire logic data_valid_o // Strobe
);
  logic [5:0] ctrl_reg;
  logic [15:0] gap_reg;
  logic [3:0] byp_reg;
  logic [1:0] cnt_reg;
  logic acc;
  logic wr;
  logic [15:0] exp_gap;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Decodes and expected word spacing in clocks
  assign acc = psel && penable;
  assign wr = acc && pwrite && paddr == CTRL_OFS;
  assign exp_gap = (ctrl_reg[4:2] > 3'h4 ? 16'h0020 :
    16'h0200 >> ctrl_reg[4:2]) * (ctrl_reg[1] ? 16'h0020 : 16'h0001);
  // Two words after a write are skipped: a stale strobe may trail it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg <= CTRL_RST;
      gap_reg <= 16'h0001;
      byp_reg <= 4'h0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (wr)
        ctrl_reg <= pwdata[5:0];
      gap_reg <= data_valid_o ? 16'h0001 : gap_reg + 16'h0001;
      byp_reg <= (wr || ctrl_reg[1:0] != 2'h0) ? 4'h0 :
        byp_reg + {3'h0, byp_reg != 4'hF};
      cnt_reg <= wr ? 2'h0 :
        cnt_reg + {1'b0, data_valid_o && cnt_reg != 2'h2};
    end
  end
  a_err_unmapped: assert property (acc && (paddr > DATA_OFS ||
    paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && paddr <= DATA_OFS &&
    paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_ctrl_readback: assert property (
    acc && !pwrite && paddr == CTRL_OFS |-> prdata[5:0] == ctrl_reg)
    else $error("control readback wrong");
  a_valid_pulse: assert property (
    data_valid_o |=> !data_valid_o)
    else $error("strobe longer than one cycle");
  a_bypass_bit: assert property (
    data_valid_o && byp_reg == 4'hF |-> data_o[0] == $past(mod_bit_i))
    else $error("bypass bit wrong");
  a_bypass_rate: assert property (
    data_valid_o && byp_reg == 4'hF |->
    $past(data_valid_o, 4) && !$past(data_valid_o, 2))
    else $error("bypass spacing wrong");
  a_sinc_spacing: assert property (
    data_valid_o && cnt_reg == 2'h2 && ctrl_reg[1:0] == 2'h1 |->
    gap_reg == exp_gap)
    else $error("sinc spacing wrong");
  a_fir_spacing: assert property (
    data_valid_o && cnt_reg == 2'h2 && ctrl_reg[1] |-> gap_reg == exp_gap)
    else $error("fir spacing wrong");
  a_status_order: assert property (
    acc && !pwrite && paddr == STATUS_OFS && prdata[1] |-> prdata[0])
    else $error("settled before in range");
  c_bypass: cover property (data_valid_o && byp_reg == 4'hF);
  c_sinc: cover property (data_valid_o && ctrl_reg[1:0] == 2'h1);
  c_fir: cover property (data_valid_o && ctrl_reg[1]);
endmodule : decim_chk
bind decimation_filter_chain decim_chk i_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .mod_bit_i(mod_bit_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_o(data_o),
  .data_valid_o(data_valid_o));

//--- tb/decimation_filter_chain_tb.sv
// Self-checking bench for the decimation filter chain
`timescale 1ns/1ps
module decimation_filter_chain_tb
  import decim_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] pat = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [DAT_W-1:0] data_o;
  logic data_valid_o;
  logic mod_bit;
  logic bit_d = 1'b0;
  logic [31:0] rd;
  logic [31:0] w;
  int n_mismatch = 0;
  int comparisons = 0;
  int gap;
  // Clock and the bit the design took one edge ago
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) bit_d <= mod_bit;
  mod_source i_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .pat_i(pat),
    .mod_bit_o(mod_bit));
  decimation_filter_chain i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mod_bit_i(mod_bit), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_o(data_o), .data_valid_o(data_valid_o));
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  // Clocks per output word: four per modulator bit, FIR multiplies by 32
  function automatic int word_gap(input int r, input logic fir);
    word_gap = (r > 4 ? 32 : 512 >> r) * (fir ? 32 : 1);
  endfunction : word_gap
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic [7:0] a, input logic wr,
    input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = pslverr === 1'b1 ? 32'hEEEEEEEE : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : apb
  // Bounded wait for the next word strobe
  task automatic wait_valid;
    gap = 0;
    do
    begin
      @(posedge clk_i);
      gap++;
    end
    while (data_valid_o !== 1'b1 && gap < 20000);
    if (gap >= 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : wait_valid
  initial
  begin
    void'($urandom(32'hE47833ED));
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(CTRL_OFS, 1'b0, 32'h0);
    chk_val(rd, {26'h0, CTRL_RST});
    apb(HPC_HI_OFS, 1'b0, 32'h0);
    chk_val(rd, {24'h0, HPC_RST[15:8]});
    apb(8'h14, 1'b0, 32'h0);
    chk_val(rd, 32'hEEEEEEEE);
    w = $urandom;
    apb(HPC_LO_OFS, 1'b1, w);
    apb(HPC_LO_OFS, 1'b0, 32'h0);
    chk_val(rd, {24'h0, w[7:0]});
    $display("test registers done");
    pat <= $urandom;
    apb(CTRL_OFS, 1'b1, 32'h0);
    wait_valid();
    repeat (8)
    begin
      wait_valid();
      chk_val(gap, 4);
      chk_val({31'h0, data_o[0]}, {31'h0, bit_d});
    end
    $display("test bypass done");
    pat <= 32'hFFFFFFFF;
    for (int r = 0; r < 6; r++)
    begin
      apb(CTRL_OFS, 1'b1, {26'h0, 1'($urandom), 3'(r), 2'h1});
      repeat (8) wait_valid();
      chk_val(gap, word_gap(r, 1'b0));
      chk_val({8'h0, data_o}, 32'h007FFFFF);
      apb(DATA_OFS, 1'b0, 32'h0);
      chk_val(rd, 32'h007FFFFF);
    end
    $display("test sinc done");
    apb(CTRL_OFS, 1'b1, 32'h00000012);
    for (int k = 1; k <= 62; k++)
    begin
      wait_valid();
      if (k > 1 && k < 30)
        chk_val(gap, word_gap(4, 1'b1));
      if (k == 30 || k == 31 || k == 61 || k == 62)
      begin
        apb(STATUS_OFS, 1'b0, 32'h0);
        chk_val(rd & 32'h3, {30'h0, k >= 62, k >= 31});
      end
    end
    $display("test fir done");
    apb(CTRL_OFS, 1'b1, 32'h0000003F);
    repeat (3) wait_valid();
    chk_val(gap, word_gap(7, 1'b1));
    $display("test highpass done");
    tally_and_finish();
  end
endmodule : decimation_filter_chain_tb
